/* isd_pkg.sv */
// constants shared by the serial-clock divider and interrupt-enable block
// assumes a single 200 mhz bus clock and an axi4-lite register port
package isd_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [31:0] ADDR_STATUS = 32'h400a0004;
    localparam logic [31:0] ADDR_CONTROL = 32'h400a0008;
    localparam logic [31:0] ADDR_SCL_HIGH = 32'h400a000c;
    localparam logic [31:0] ADDR_SCL_LOW = 32'h400a0010;

    // ****************************************************************
    // field positions, shared by control enables and status flags, except soft reset bit 8, which is control only
    // ****************************************************************
    localparam int BIT_TRANSACTION_DONE = 0;
    localparam int BIT_NO_ACK = 2;
    localparam int BIT_DATA_REQUEST = 3;
    localparam int BIT_SOFT_RESET = 8;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_FIELD_MASK = 4'hd;
    localparam logic [3:0] READ_CLEAR_MASK = 4'hc;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam int COUNT_W = 10;
    localparam logic [9:0] SCL_COUNT_RESET = 10'h3ff;
    localparam logic [9:0] SCL_COUNT_ONE = 10'h001;

    // ****************************************************************
    // bus answers and state encodings
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ISD_SCL_HIGH = 1'b0,
        ISD_SCL_LOW = 1'b1
    } isd_phase_e;

endpackage : isd_pkg

/* isd_scl_gen.sv */
// serial clock generator: counts bus clocks against the high and low terminal counts
// assumes scl_in is the resolved bus level, already synchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module isd_scl_gen
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic run,
    input wire logic hold,
    input wire logic [isd_pkg::COUNT_W-1:0] high_count,
    input wire logic [isd_pkg::COUNT_W-1:0] low_count,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic scl_rise,
    output logic scl_fall
);

    typedef struct packed {
        isd_pkg::isd_phase_e phase;
        logic [isd_pkg::COUNT_W-1:0] cnt;
        logic rise;
        logic fall;
    } isd_gen_s;

    isd_gen_s st_ff;
    isd_gen_s nxt_st;
    logic [isd_pkg::COUNT_W-1:0] high_tc;
    logic [isd_pkg::COUNT_W-1:0] low_tc;

    // a zero count acts as one, so each phase lasts at least one cycle
    assign high_tc = (high_count == '0) ? isd_pkg::SCL_COUNT_ONE : high_count;
    assign low_tc = (low_count == '0) ? isd_pkg::SCL_COUNT_ONE : low_count;

    // ****************************************************************
    // phase counter
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rise = 1'b0;
        nxt_st.fall = 1'b0;
        if (!run || soft_reset)
        begin
            nxt_st.phase = isd_pkg::ISD_SCL_HIGH;
            nxt_st.cnt = isd_pkg::SCL_COUNT_ONE;
        end
        else
        begin
            // R8 - period high plus low
            case (st_ff.phase)
                isd_pkg::ISD_SCL_HIGH:
                begin
                    // a slave stretching the clock pauses the high count
                    if (scl_in)
                    begin
                        // R5 - high period count
                        if (st_ff.cnt >= high_tc)
                        begin
                            nxt_st.phase = isd_pkg::ISD_SCL_LOW;
                            nxt_st.cnt = isd_pkg::SCL_COUNT_ONE;
                            nxt_st.fall = 1'b1;
                        end
                        else
                        begin
                            nxt_st.cnt = st_ff.cnt + isd_pkg::SCL_COUNT_ONE;
                        end
                    end
                end
                isd_pkg::ISD_SCL_LOW:
                begin
                    // R6 - low period count
                    if (st_ff.cnt >= low_tc)
                    begin
                        // R1 - hold scl low
                        if (!hold)
                        begin
                            nxt_st.phase = isd_pkg::ISD_SCL_HIGH;
                            nxt_st.cnt = isd_pkg::SCL_COUNT_ONE;
                            nxt_st.rise = 1'b1;
                        end
                    end
                    else
                    begin
                        nxt_st.cnt = st_ff.cnt + isd_pkg::SCL_COUNT_ONE;
                    end
                end
                default:
                begin
                    nxt_st.phase = isd_pkg::ISD_SCL_HIGH;
                    nxt_st.cnt = isd_pkg::SCL_COUNT_ONE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '{isd_pkg::ISD_SCL_HIGH, isd_pkg::SCL_COUNT_ONE, 1'b0, 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // open drain: only ever pulls low
    assign scl_out = 1'b0;
    assign scl_oe = (st_ff.phase == isd_pkg::ISD_SCL_LOW);
    assign scl_rise = st_ff.rise;
    assign scl_fall = st_ff.fall;

endmodule : isd_scl_gen

`default_nettype wire

/* isd_irq_status.sv */
// sticky interrupt flags with enable gating onto one level interrupt
// assumes event inputs are one-cycle pulses from the transfer engine
`timescale 1ns/1ps
`default_nettype none

module isd_irq_status
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic [isd_pkg::IRQ_W-1:0] event_set,
    input wire logic read_clear,
    input wire logic done_w1c,
    input wire logic [isd_pkg::IRQ_W-1:0] enable,
    output logic [isd_pkg::IRQ_W-1:0] status,
    output logic irq
);

    typedef struct packed {
        logic [isd_pkg::IRQ_W-1:0] sts;
        logic irq;
    } isd_sts_s;

    isd_sts_s st_ff;
    isd_sts_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // R12 - soft reset clears
        if (soft_reset)
        begin
            nxt_st.sts = isd_pkg::STATUS_RESET;
        end
        if (read_clear)
        begin
            nxt_st.sts = nxt_st.sts & ~isd_pkg::READ_CLEAR_MASK;
        end
        // R13 - done cleared by one
        if (done_w1c)
        begin
            nxt_st.sts[isd_pkg::BIT_TRANSACTION_DONE] = 1'b0;
        end
        // an event in the clearing cycle is kept
        nxt_st.sts = nxt_st.sts | (event_set & isd_pkg::IRQ_FIELD_MASK);
        // R14 - enabled flag raises irq
        nxt_st.irq = |(nxt_st.sts & enable & isd_pkg::IRQ_FIELD_MASK);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '{isd_pkg::STATUS_RESET, 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign status = st_ff.sts;
    assign irq = st_ff.irq;

endmodule : isd_irq_status

`default_nettype wire

/* isd_top.sv */
// register file, axi4-lite slave and hook-up of the scl divider and interrupt flags
// assumes a transfer engine outside drives the events, run and hold, and takes soft_reset
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - control bit 3 enables data-request irq; scl held low when data runs out
// R2 - control bit 2 enables the no-acknowledge irq
// R3 - control bit 0 enables transaction-done irq; bit 1 unused
// R4 - the three enables reset to zero; writing one enables
// R5 - high count register bits 9:0 set scl high cycles
// R6 - low count register bits 9:0 set scl low cycles
// R7 - both counts reset to 0x3ff, the slowest scl
// R8 - scl rate is bus clock over high plus low count
// R9 - software uses equal counts for 100 khz
// R10 - software uses a longer low count for 400 khz
// R11 - maximum counts give the lowest reachable scl rate
// R12 - control bit 8 soft reset self clears, keeps divider and control
// R13 - done flag set on completion, cleared by writing one to status bit 0
// R14 - irq high while a flag is set with its enable
module isd_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic data_request_irq,
    input wire logic no_ack_irq,
    input wire logic transaction_done,
    input wire logic scl_run,
    input wire logic scl_hold,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic scl_rise,
    output logic scl_fall,
    output logic soft_reset,
    output logic irq
);

    typedef struct packed {
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [isd_pkg::IRQ_W-1:0] enable;
        logic [isd_pkg::COUNT_W-1:0] high_cnt;
        logic [isd_pkg::COUNT_W-1:0] low_cnt;
        logic soft_rst;
    } isd_regs_s;

    isd_regs_s st_ff;
    isd_regs_s nxt_st;
    logic [isd_pkg::IRQ_W-1:0] status;
    logic [isd_pkg::IRQ_W-1:0] event_set;
    logic status_read;
    logic done_w1c;
    logic [31:0] wmerge;
    logic [31:0] read_word;
    logic read_hit;

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    // one write answered at a time; new address and data wait for bready
    assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    // ****************************************************************
    // read decode
    // ****************************************************************
    always_comb
    begin
        read_word = '0;
        read_hit = 1'b1;
        case (s_axi_araddr)
            isd_pkg::ADDR_STATUS:
            begin
                read_word[isd_pkg::IRQ_W-1:0] = status;
            end
            isd_pkg::ADDR_CONTROL:
            begin
                // R3 - bit 1 reads zero
                read_word[isd_pkg::IRQ_W-1:0] = st_ff.enable & isd_pkg::IRQ_FIELD_MASK;
            end
            isd_pkg::ADDR_SCL_HIGH:
            begin
                read_word[isd_pkg::COUNT_W-1:0] = st_ff.high_cnt;
            end
            isd_pkg::ADDR_SCL_LOW:
            begin
                read_word[isd_pkg::COUNT_W-1:0] = st_ff.low_cnt;
            end
            default:
            begin
                read_hit = 1'b0;
            end
        endcase
    end

    // a status read clears the read-to-clear flags as it is taken
    assign status_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == isd_pkg::ADDR_STATUS);

    // byte-lane merge of the held write data onto zero
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wmerge[8*i +: 8] = st_ff.wstrb[i] ? st_ff.wdata[8*i +: 8] : 8'h00;
        end
    end

    assign done_w1c = st_ff.aw_held && st_ff.w_held && (st_ff.awaddr == isd_pkg::ADDR_STATUS)
                      && wmerge[isd_pkg::BIT_TRANSACTION_DONE];

    // ****************************************************************
    // register state
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        // R12 - self clearing pulse
        nxt_st.soft_rst = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_held && st_ff.w_held)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = isd_pkg::RESP_OKAY;
            case (st_ff.awaddr)
                isd_pkg::ADDR_STATUS:
                begin
                    nxt_st.bresp = isd_pkg::RESP_OKAY;
                end
                isd_pkg::ADDR_CONTROL:
                begin
                    // R4 - write one enables
                    if (st_ff.wstrb[0])
                    begin
                        nxt_st.enable = st_ff.wdata[isd_pkg::IRQ_W-1:0] & isd_pkg::IRQ_FIELD_MASK;
                    end
                    // R12 - soft reset request
                    nxt_st.soft_rst = wmerge[isd_pkg::BIT_SOFT_RESET];
                end
                isd_pkg::ADDR_SCL_HIGH:
                begin
                    // R5 - store high count
                    nxt_st.high_cnt = (wmerge[isd_pkg::COUNT_W-1:0] & {{2{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}})
                                      | (st_ff.high_cnt & ~{{2{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}});
                end
                isd_pkg::ADDR_SCL_LOW:
                begin
                    // R6 - store low count
                    nxt_st.low_cnt = (wmerge[isd_pkg::COUNT_W-1:0] & {{2{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}})
                                     | (st_ff.low_cnt & ~{{2{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}});
                end
                default:
                begin
                    nxt_st.bresp = isd_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = read_word;
            nxt_st.rresp = read_hit ? isd_pkg::RESP_OKAY : isd_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // R4 - enables off
            // R7 - slowest divider
            st_ff <= '{1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000, 4'h0, 1'b0, isd_pkg::RESP_OKAY,
                       1'b0, 32'h0000_0000, isd_pkg::RESP_OKAY, isd_pkg::ENABLE_RESET,
                       isd_pkg::SCL_COUNT_RESET, isd_pkg::SCL_COUNT_RESET, 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign soft_reset = st_ff.soft_rst;

    // ****************************************************************
    // interrupt flags
    // ****************************************************************
    always_comb
    begin
        event_set = '0;
        // R1 - data request flag
        event_set[isd_pkg::BIT_DATA_REQUEST] = data_request_irq;
        // R2 - no acknowledge flag
        event_set[isd_pkg::BIT_NO_ACK] = no_ack_irq;
        // R13 - done flag set
        event_set[isd_pkg::BIT_TRANSACTION_DONE] = transaction_done;
    end

    isd_irq_status u_irq_status
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .soft_reset(st_ff.soft_rst),
        .event_set(event_set),
        .read_clear(status_read),
        .done_w1c(done_w1c),
        .enable(st_ff.enable),
        .status(status),
        .irq(irq)
    );

    // ****************************************************************
    // serial clock
    // ****************************************************************
    // R11 - 0x3ff counts give the slowest rate the divider can reach
    isd_scl_gen u_scl_gen
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .soft_reset(st_ff.soft_rst),
        .run(scl_run),
        .hold(scl_hold),
        .high_count(st_ff.high_cnt),
        .low_count(st_ff.low_cnt),
        .scl_in(scl_in),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall)
    );

endmodule : isd_top

`default_nettype wire

/* isd_top_sva.sv */
// checker for the divider and interrupt-enable block, bound to isd_top
// assumes it sees only the ports of isd_top
`timescale 1ns/1ps
`default_nettype none

module isd_top_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic data_request_irq,
    input wire logic no_ack_irq,
    input wire logic transaction_done,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic scl_fall,
    input wire logic soft_reset,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ********
    // register bus
    // ********
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer not two cycles on");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
    property p_w_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken while response pending");

    // ********
    // control and line
    // ********
    property p_sr_pulse;
        soft_reset |=> !soft_reset;
    endproperty
    a_sr_pulse: assert property (p_sr_pulse) else $error("soft reset not self clearing");
    property p_irq_cause;
        $rose(irq) |-> $past(data_request_irq || no_ack_irq || transaction_done) || $past(s_axi_bvalid);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_scl_low;
        $rose(scl_oe) |-> scl_fall && !scl_out;
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("scl low phase unmarked");
endmodule : isd_top_sva

bind isd_top isd_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .data_request_irq(data_request_irq),
    .no_ack_irq(no_ack_irq), .transaction_done(transaction_done), .scl_out(scl_out),
    .scl_oe(scl_oe), .scl_fall(scl_fall), .soft_reset(soft_reset), .irq(irq));

`default_nettype wire

/* isd_scl_slave.sv */
// serial-side partner: pulled-up scl line with a slave that may stretch it
// assumes scl_oe from the block is registered on aclk
`timescale 1ns/1ps
`default_nettype none

module isd_scl_slave
(
    input wire logic aclk,
    input wire logic scl_oe,
    input wire logic stretch,
    output logic scl_in
);
    logic stretch_ff;

    // stretch lands a cycle late, as a slow slave would
    always_ff @(posedge aclk)
    begin
        stretch_ff <= stretch;
    end

    // released line floats to the pull-up level
    assign scl_in = !(scl_oe || stretch_ff);
endmodule : isd_scl_slave

`default_nettype wire

/* isd_top_tb_top.sv */
// self-checking bench for the divider and interrupt-enable block
// assumes the checker is bound from its own file and the scl partner sits beside
`timescale 1ns/1ps
`default_nettype none

module isd_top_tb_top;
    localparam logic [31:0] A_ST = isd_pkg::ADDR_STATUS;
    localparam logic [31:0] A_CT = isd_pkg::ADDR_CONTROL;
    localparam logic [31:0] A_HI = isd_pkg::ADDR_SCL_HIGH;
    localparam logic [31:0] A_LO = isd_pkg::ADDR_SCL_LOW;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, hold, stretch, scl_in;
    logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, fall, rise, srst, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] ev;
    logic [11:0] lo_n, fall_n;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_mismatch, check_count, cyc, seed;

    isd_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_request_irq(ev[2]),
        .no_ack_irq(ev[1]), .transaction_done(ev[0]), .scl_run(run), .scl_hold(hold), .scl_in(scl_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .scl_rise(rise), .scl_fall(fall), .soft_reset(srst), .irq(irq));
    isd_scl_slave slave_u (.aclk(aclk), .scl_oe(scl_oe), .stretch(stretch), .scl_in(scl_in));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ********
    // tasks
    // ********
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        // an answer that never came leaves its note behind
        if (rq.size() + bq.size() > 0) n_mismatch++;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [31:0] a, input logic [31:0] dw, input logic [3:0] s = 4'hf,
        input logic [1:0] r = isd_pkg::RESP_OKAY);
        bq.push_back(r);
        awaddr <= a;
        wdata <= dw;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        repeat (200)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = isd_pkg::RESP_OKAY);
        rq.push_back({r, e});
        araddr <= a;
        arvalid <= 1'b1;
        repeat (200)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
    endtask : rd

    task automatic pulse(input int i);
        ev <= 3'h1 << i;
        @(posedge aclk);
        ev <= 3'h0;
    endtask : pulse

    task automatic watch();
        lo_n = 0;
        fall_n = 0;
        repeat (20)
        begin
            @(posedge aclk);
            lo_n += 12'(!scl_oe);
            fall_n += 12'(fall);
        end
    endtask : watch

    // one full period, fall to fall, after parking the line high
    task automatic scl_meas(input logic [11:0] h, input logic [11:0] l);
        logic [11:0] p, lo, r;
        p = 0;
        lo = 0;
        r = 0;
        run <= 1'b1;
        for (int t = 0; t < 5000 && !fall; t++) @(posedge aclk);
        do
        begin
            @(posedge aclk);
            p++;
            lo += 12'(scl_oe);
            r += 12'(rise);
        end
        while (!fall && p < 12'd2100);
        chk(34'(p), 34'(h + l));
        chk(34'(r), 34'h1);
        chk(34'(lo), 34'(l));
    endtask : scl_meas

    // ********
    // monitor: answers against noted expectations, ready stalls, timeout
    // ********
    always @(posedge aclk)
    begin
        cyc++;
        if (rvalid && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready && bq.size() > 0) chk(34'(bresp), 34'(bq.pop_front()));
        rready <= (rready && !rvalid) ? 1'b1 : 1'($random(seed));
        bready <= (bready && !bvalid) ? 1'b1 : 1'($random(seed));
        if (cyc > 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        seed = 32'h8619;
        {aresetn, awvalid, wvalid, arvalid, bready, rready, run, hold, stretch} = '0;
        {awaddr, wdata, araddr, wstrb, ev, n_mismatch, check_count, cyc} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CT, 32'h0);
        rd(A_HI, 32'h3ff);
        rd(A_LO, 32'h3ff);
        scl_meas(12'h3ff, 12'h3ff);
        run <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            wr(A_HI, d);
            rd(A_HI, d & 32'h3ff);
            wr(A_LO, ~d);
            rd(A_LO, ~d & 32'h3ff);
        end
        wr(32'h400a0014, 32'hffffffff, 4'hf, isd_pkg::RESP_SLVERR);
        rd(32'h400a0014, 32'h0, isd_pkg::RESP_SLVERR);
        // masked event sets its flag but leaves irq low
        pulse(1);
        repeat (3) @(posedge aclk);
        chk(34'(irq), 34'h0);
        rd(A_ST, 32'h4);
        rd(A_ST, 32'h0);
        wr(A_CT, 32'hf);
        rd(A_CT, 32'hd);
        for (int i = 0; i < 3; i++)
        begin
            pulse(i);
            repeat (3) @(posedge aclk);
            chk(34'(irq), 34'h1);
            rd(A_ST, 32'h1 << (i + (i > 0)));
            if (i == 0)
            begin
                rd(A_ST, 32'h1);
                wr(A_ST, 32'h1);
            end
            repeat (2) @(posedge aclk);
            chk(34'(irq), 34'h0);
        end
        pulse(1);
        wr(A_CT, 32'h10d, 4'h3);
        rd(A_ST, 32'h0);
        rd(A_CT, 32'hd);
        rd(A_HI, d & 32'h3ff);
        wr(A_HI, 32'h3);
        wr(A_LO, 32'h5);
        scl_meas(12'd3, 12'd5);
        hold <= 1'b1;
        repeat (12) @(posedge aclk);
        watch();
        chk(34'(lo_n), 34'h0);
        hold <= 1'b0;
        stretch <= 1'b1;
        repeat (6) @(posedge aclk);
        watch();
        chk(34'(fall_n), 34'h0);
        stretch <= 1'b0;
        run <= 1'b0;
        wr(A_HI, 32'h4);
        wr(A_LO, 32'h4);
        scl_meas(12'd4, 12'd4);
        complete_run();
    end
endmodule : isd_top_tb_top

`default_nettype wire
